// ===== inc/sarsf_regs.svh
// timing and frame constants of the serial conversion frame
`ifndef SARSF_REGS_SVH
`define SARSF_REGS_SVH
`define SARSF_LEAD_BITS  5'h04
`define SARSF_TRAIL_BITS 5'h02
`define SARSF_ACQ_EDGE   5'h0d
`define SARSF_CONV_EDGE  5'h0e
`define SARSF_PD_LO_EDGE 5'h02
`define SARSF_PD_HI_EDGE 5'h0a
`define SARSF_WAKE_EDGE  5'h0b
`define SARSF_CLK_NS     10
`define SARSF_WAKE_NS    800
`define SARSF_QUIET_NS   40
`endif

// ===== inc/sarsf_pkg.sv
// types shared by the serial conversion frame logic
package sarsf_pkg;
  typedef enum logic [1:0] {
    SARSF_IDLE,
    SARSF_FRAME,
    SARSF_DONE
  } sarsf_phase_t;
endpackage : sarsf_pkg

// ===== verilog/sarsf_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sarsf_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // pins
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  // synchronised levels
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sarsf_sync_t;

  sarsf_sync_t q_q;
  sarsf_sync_t q_d;

  initial begin
    if (W < 1) $error("sarsf_sync: width must be positive");
  end

  // ****************
  // two stage chain
  // ****************
  always_comb begin
    q_d = q_q;
    for (int i = 0; i < W; i++) begin
      q_d.s1[i] = async_in[i];
      q_d.s2[i] = q_q.s1[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= '1;
    end else begin
      q_q <= q_d;
    end
  end

  assign sync_out = q_q.s2;
endmodule : sarsf_sync

// ===== verilog/sarsf_frame.sv
// serial conversion frame logic of the converter
`timescale 1ns/1ps
`include "sarsf_regs.svh"
module sarsf_frame #(
  parameter int DATA_W = 10
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // host link pins
  input  wire logic              frame_sel_n,
  input  wire logic              serial_clk,
  output logic                   serial_out,
  output logic                   serial_out_oe,
  // converter core
  input  wire logic [DATA_W-1:0] analog_input,
  // status
  output logic                   conv_busy,
  output logic                   acq_phase,
  output logic                   power_down,
  output logic                   result_valid
);
  localparam int WORD_W = int'(`SARSF_LEAD_BITS) + DATA_W + int'(`SARSF_TRAIL_BITS);
  localparam int WAKE_CYC = (`SARSF_WAKE_NS + `SARSF_CLK_NS - 1) / `SARSF_CLK_NS;
  localparam logic [4:0] FLOAT_EDGE = 5'(WORD_W);
  localparam logic [7:0] WAKE_CNT   = 8'(WAKE_CYC);

  initial begin
    if (WORD_W != 16 || WAKE_CYC > 255) $error("sarsf_frame: unsupported width");
  end

  typedef struct packed {
    sarsf_pkg::sarsf_phase_t ph;
    logic [4:0]              cnt;
    logic [WORD_W-1:0]       word;
    logic                    cs_prev;
    logic                    ck_prev;
    logic                    out;
    logic                    oe;
    logic                    busy;
    logic                    acq;
    logic                    acq_ok;
    logic                    frame_ok;
    logic                    pd;
    logic [7:0]              wake;
    logic                    valid;
  } sarsf_frame_t;

  sarsf_frame_t st_q;
  sarsf_frame_t st_d;
  logic [1:0]   pins_s;
  logic         cs_s;
  logic         ck_s;
  logic         cs_fall;
  logic         cs_rise;
  logic         ck_fall;
  logic         ck_rise;
  logic [4:0]   cnt_nx;

  // ****************
  // pin capture
  // ****************
  sarsf_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({frame_sel_n, serial_clk}),
    .rst_val  (2'h3),
    .sync_out (pins_s)
  );

  assign cs_s    = pins_s[1];
  assign ck_s    = pins_s[0];
  assign cs_fall = st_q.cs_prev && !cs_s;
  assign cs_rise = !st_q.cs_prev && cs_s;
  assign ck_fall = st_q.ck_prev && !ck_s;
  assign ck_rise = !st_q.ck_prev && ck_s;
  assign cnt_nx  = st_q.cnt + 5'h01;

  // ****************
  // frame sequencer
  // ****************
  always_comb begin
    st_d         = st_q;
    st_d.cs_prev = cs_s;
    st_d.ck_prev = ck_s;
    if (st_q.wake != 8'h00) begin
      st_d.wake = st_q.wake - 8'h01;
    end
    unique case (st_q.ph)
      sarsf_pkg::SARSF_IDLE: begin
        st_d.oe = 1'b0;
        if (cs_fall) begin
          st_d.ph       = sarsf_pkg::SARSF_FRAME;
          st_d.cnt      = 5'h00;
          st_d.word     = {`SARSF_LEAD_BITS'(0), analog_input, `SARSF_TRAIL_BITS'(0)};
          st_d.frame_ok = st_q.acq_ok && !st_q.pd && st_q.wake == 8'h00;
          st_d.acq_ok   = 1'b0;
          st_d.acq      = 1'b0;
          st_d.valid    = 1'b0;
          st_d.busy     = !st_q.pd;
          st_d.oe       = !st_q.pd;
          st_d.out      = 1'b0;
        end
      end
      sarsf_pkg::SARSF_FRAME: begin
        if (cs_rise) begin
          st_d.ph   = sarsf_pkg::SARSF_IDLE;
          st_d.oe   = 1'b0;
          st_d.busy = 1'b0;
          if (st_q.cnt >= `SARSF_PD_LO_EDGE && st_q.cnt < `SARSF_PD_HI_EDGE) begin
            st_d.pd = 1'b1;
          end
        end else if (ck_fall) begin
          st_d.cnt = cnt_nx;
          st_d.out = st_q.word[WORD_W-1-int'(cnt_nx[3:0])];
          if (cnt_nx == `SARSF_CONV_EDGE && st_q.busy) begin
            st_d.busy  = 1'b0;
            st_d.valid = st_q.frame_ok;
          end
          if (st_q.pd && cnt_nx == `SARSF_WAKE_EDGE) begin
            st_d.pd   = 1'b0;
            st_d.wake = WAKE_CNT;
          end
          if (cnt_nx == FLOAT_EDGE) begin
            st_d.ph  = sarsf_pkg::SARSF_DONE;
            st_d.oe  = 1'b0;
            st_d.out = 1'b0;
          end
        end else if (ck_rise && st_q.cnt >= `SARSF_ACQ_EDGE && !st_q.pd && !st_q.acq) begin
          st_d.acq    = 1'b1;
          st_d.acq_ok = 1'b1;
        end
      end
      sarsf_pkg::SARSF_DONE: begin
        st_d.oe = 1'b0;
        if (ck_rise && !st_q.pd && !st_q.acq) begin
          st_d.acq    = 1'b1;
          st_d.acq_ok = 1'b1;
        end
        if (cs_rise) begin
          st_d.ph = sarsf_pkg::SARSF_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.ph       <= sarsf_pkg::SARSF_IDLE;
      st_q.cs_prev  <= 1'b1;
      st_q.ck_prev  <= 1'b1;
      st_q.acq      <= 1'b1;
      st_q.acq_ok   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign serial_out    = st_q.out;
  assign serial_out_oe = st_q.oe;
  assign conv_busy     = st_q.busy;
  assign acq_phase     = st_q.acq;
  assign power_down    = st_q.pd;
  assign result_valid  = st_q.valid;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_start_zero_out: assert property (
    st_q.ph == sarsf_pkg::SARSF_IDLE && cs_fall && !st_q.pd |=> serial_out_oe && !serial_out
  ) else $error("frame start did not drive the first zero");

  a_word_bit_order: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && st_q.oe |-> st_q.out == st_q.word[WORD_W-1-int'(st_q.cnt[3:0])]
  ) else $error("serial bit does not match word position");

  a_change_on_fall: assert property (
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> $past(ck_fall)
  ) else $error("serial output changed without a clock fall");

  a_conv_end_edge: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && ck_fall && !cs_rise && cnt_nx == `SARSF_CONV_EDGE
    |=> !conv_busy
  ) else $error("conversion still busy after fourteenth fall");

  a_acq_entry: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && !cs_rise && !ck_fall && ck_rise && !st_q.pd
    && st_q.cnt >= `SARSF_ACQ_EDGE |=> acq_phase
  ) else $error("acquisition not entered after thirteenth fall");

  a_float_sixteen: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && ck_fall && !cs_rise && cnt_nx == FLOAT_EDGE
    |=> !serial_out_oe ##1 !serial_out_oe
  ) else $error("output not floated at sixteenth fall");

  a_abort_float: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && cs_rise |=> !serial_out_oe && !conv_busy
  ) else $error("abort did not float output");

  a_pd_entry: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && cs_rise && st_q.cnt >= `SARSF_PD_LO_EDGE
    && st_q.cnt < `SARSF_PD_HI_EDGE |=> power_down
  ) else $error("power-down not entered");

  a_wake_exit: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && st_q.pd && ck_fall && !cs_rise
    && cnt_nx == `SARSF_WAKE_EDGE |=> !power_down && st_q.wake == WAKE_CNT
  ) else $error("dummy frame did not wake the device");

  a_skip_invalid: assert property (
    st_q.ph == sarsf_pkg::SARSF_FRAME && cs_rise && !st_q.acq
    ##1 (st_q.ph == sarsf_pkg::SARSF_IDLE && cs_fall) |=> !st_q.frame_ok
  ) else $error("frame after skipped acquisition marked valid");

  a_idle_float: assert property (
    st_q.ph == sarsf_pkg::SARSF_IDLE && $past(st_q.ph) == sarsf_pkg::SARSF_IDLE |-> !serial_out_oe
  ) else $error("output driven outside a frame");
endmodule : sarsf_frame

// ===== tb/sarsf_host.sv
// host controller model driving frame select and serial clock
`timescale 1ns/1ps
module sarsf_host (
  // clock and request from bench
  input  wire logic        core_clk,
  input  wire logic        start,
  input  wire logic [4:0]  n_falls,
  input  wire logic [1:0]  ph,
  // link pins
  output logic             frame_sel_n,
  output logic             serial_clk,
  input  wire logic        serial_out,
  input  wire logic        serial_out_oe,
  // captured frame
  output logic [15:0]      cap_word,
  output logic [15:0]      cap_oe,
  output logic             end_oe,
  output logic             done
);
  logic line_q;
  initial begin
    frame_sel_n = 1'b1;
    serial_clk  = 1'b1;
    done        = 1'b0;
    line_q      = 1'b0;
    end_oe      = 1'b0;
  end
  // ****************
  // one frame per request; clock stands high between frames
  // ****************
  always @(posedge core_clk) begin
    if (!start) begin
      done = 1'b0;
    end else if (!done) begin
      cap_word = 16'h0000;
      cap_oe   = 16'h0000;
      #(ph);
      frame_sel_n = 1'b0;
      #40;
      for (int k = 1; k <= n_falls; k++) begin
        #39;
        line_q = serial_out_oe ? serial_out : ~line_q;
        cap_word[16-k] = line_q;
        cap_oe[16-k] = serial_out_oe;
        #1 serial_clk = 1'b0;
        #40 serial_clk = 1'b1;
      end
      #40 frame_sel_n = 1'b1;
      #60 end_oe = serial_out_oe;
      done = 1'b1;
    end
  end
endmodule : sarsf_host

// ===== tb/sar_adc_serial_frame_bench.sv
// self-checking bench of the serial conversion frame logic
`timescale 1ns/1ps
module sar_adc_serial_frame_bench;
  typedef struct packed {logic [34:0] e; logic [34:0] m;} sarsf_exp_t;
  logic        core_clk, rst_n, start, done, end_oe;
  logic        frame_sel_n, serial_clk, serial_out, serial_out_oe;
  logic        power_down, result_valid;
  logic [4:0]  n_falls;
  logic [1:0]  ph;
  logic [9:0]  analog_input;
  logic [15:0] cap_word, cap_oe;
  int          seed, n_mismatch, samples_checked;
  int          ab[5] = '{1, 2, 9, 10, 12};
  sarsf_exp_t  q[$];
  sarsf_frame u_dut (.core_clk(core_clk), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .analog_input(analog_input), .conv_busy(), .acq_phase(), .power_down(power_down),
    .result_valid(result_valid));
  sarsf_host u_host (.core_clk(core_clk), .start(start), .n_falls(n_falls), .ph(ph),
    .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .cap_word(cap_word), .cap_oe(cap_oe),
    .end_oe(end_oe), .done(done));
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // ****************
  // one frame: n falls, pdf = frame run in power-down
  // ****************
  task automatic frame(input int n, input bit pdf, input bit wchk, input bit pdx,
                       input bit vx);
    logic [15:0] mn;
    sarsf_exp_t  x;
    int          i;
    mn = ~(16'hffff >> n);
    @(posedge core_clk);
    #1;
    analog_input = 10'($random(seed));
    ph = 2'(2 + ($random(seed) & 1));
    n_falls = 5'(n);
    x.e = {4'h0, analog_input, 2'b00, pdf ? 16'h0000 : mn, 1'b0, pdx, vx};
    x.m = {wchk ? mn : 16'h0000, pdf ? (mn & 16'hffe0) : mn, 3'b111};
    q.push_back(x);
    start = 1'b1;
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(posedge core_clk);
    if (done !== 1'b1) begin
      $display("[FAIL] %0t done exp %h got %h", $time, 1'b1, done);
      n_mismatch++;
      final_report();
    end
    @(posedge core_clk);
    #1 start = 1'b0;
    @(posedge core_clk);
  endtask : frame
  // result watcher
  always @(posedge done) begin
    sarsf_exp_t  x;
    logic [34:0] o;
    o = {cap_word, cap_oe, end_oe, power_down, result_valid};
    x = q.pop_front();
    samples_checked++;
    if ((o & x.m) !== (x.e & x.m)) begin
      $display("[FAIL] %0t exp %h got %h", $time, x.e & x.m, o & x.m);
      n_mismatch++;
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    bit pd;
    rst_n = 1'b0;
    start = 1'b0;
    analog_input = 10'h000;
    n_falls = 5'h00;
    ph = 2'h2;
    seed = 32'h114b;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 6; i++) frame(16, 0, 1, 0, 1);
    foreach (ab[j]) begin
      pd = (ab[j] >= 2) && (ab[j] <= 9);
      frame(ab[j], 0, 1, pd, 0);
      if (pd) frame(16, 1, 0, 0, 0);
      frame(16, 0, 0, 0, 0);
      frame(16, 0, 1, 0, 1);
    end
    final_report();
  end
endmodule : sar_adc_serial_frame_bench
